// ---- nvm_launch_pkg.sv ----
// constants, codes and register map of the nvm command launch block
// Contract
// - while command complete reads 0, launches and command array writes are ignored
// - writing 1 to command complete clears it and starts the loaded command
// - command complete stays 0 until done, then returns 1 with results in the array
// - codes 01, 02, 03 verify erase of all blocks, one block, a word range
// - code 07 programs the 64 byte once field only once; code 04 reads it
// - code 06 programs one phrase from the supplied data words
// - code 08 erases everything only with all three flash bits and eeprom open set
// - code 09 full flash block erase needs low, high disable and open bits set
// - code 0a erases the addressed program flash sector
// - code 0b unsecures by erasing and verifying all blocks
// - code 0c unsecures by comparing supplied keys against stored keys
// - codes 0d and 0e set user and field margin levels; 0e special only
// - code 13 overrides protection temporarily when the supplied key verifies
// - secured special single chip mode accepts no command code at all
// - codes 08, 0b, 0e are valid only unsecured in special single chip mode
// - code 0c is valid only in normal single chip mode
// - secured normal mode accepts the unsecured normal command set
// - command code is the high byte of array word 0
// - parameters are locked from software while a command runs
// - program or erase without a written clock divider sets access error instead
// - an invalid code sets access error and is not processed
package nvm_launch_pkg;
  // register byte offsets, one aligned word each
  localparam logic [7:0] ADDR_STATUS = 8'h00;
  localparam logic [7:0] ADDR_INDEX = 8'h04;
  localparam logic [7:0] ADDR_CLKDIV = 8'h08;
  localparam logic [7:0] ADDR_PROT = 8'h0c;
  localparam logic [7:0] ADDR_OBJ_BASE = 8'h10;
  localparam logic [7:0] ADDR_OBJ_END = 8'h28;
  localparam int OBJ_WORDS = 6;
  localparam int IDX_W = 3;
  localparam int OBJ_SEL_LSB = 2;
  // status bits
  localparam int COMMAND_COMPLETE_FLAG_BIT = 7;
  localparam int ACC_BIT = 5;
  localparam int VIOL_BIT = 4;
  // clock divider register
  localparam int DIV_W = 7;
  localparam int DIV_LOADED_BIT = 7;
  // protection register bits
  localparam int PROT_LOW_DIS_BIT = 0;
  localparam int PROT_HIGH_DIS_BIT = 1;
  localparam int PROT_PF_OPEN_BIT = 2;
  localparam int PROT_EE_OPEN_BIT = 3;
  localparam logic [3:0] PROT_RESET = 4'h0;
  localparam logic [2:0] PROT_PF_ALL = 3'h7;
  localparam logic [3:0] PROT_ALL = 4'hf;
  // global address bit that marks program flash in word 0 low byte
  localparam int PF_ADDR_BIT = 7;
  // command codes
  localparam logic [7:0] CMD_VERIFY_ALL = 8'h01;
  localparam logic [7:0] CMD_VERIFY_BLOCK = 8'h02;
  localparam logic [7:0] CMD_VERIFY_SECTION = 8'h03;
  localparam logic [7:0] CMD_READ_ONCE = 8'h04;
  localparam logic [7:0] CMD_PROGRAM = 8'h06;
  localparam logic [7:0] CMD_PROGRAM_ONCE = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;
  localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
  localparam logic [7:0] CMD_ERASE_SECTOR = 8'h0a;
  localparam logic [7:0] CMD_UNSECURE = 8'h0b;
  localparam logic [7:0] CMD_BACKDOOR = 8'h0c;
  localparam logic [7:0] CMD_USER_MARGIN = 8'h0d;
  localparam logic [7:0] CMD_FIELD_MARGIN = 8'h0e;
  localparam logic [7:0] CMD_EE_VERIFY = 8'h10;
  localparam logic [7:0] CMD_EE_PROGRAM = 8'h11;
  localparam logic [7:0] CMD_EE_ERASE = 8'h12;
  localparam logic [7:0] CMD_PROT_OVERRIDE = 8'h13;
  typedef enum logic [0:0] {
    st_idle = 1'b0,
    st_busy = 1'b1
  } launch_state_e;
endpackage

// ---- nvm_cmd_check.sv ----
// command code legality against mode, security, divider and protection
`timescale 1ns/1ps
`default_nettype none
module nvm_cmd_check (
  // command
  input wire logic [7:0] code,
  input wire logic pf_target,
  // chip state
  input wire logic special_mode,
  input wire logic secured,
  input wire logic div_loaded,
  input wire logic [3:0] prot,
  // verdict
  output logic acc_fail,
  output logic prot_fail
);
  import nvm_launch_pkg::*;
  logic listed, ss_only, ns_only, prog_erase, code_ok;
  always_comb begin
    unique case (code)
      CMD_VERIFY_ALL, CMD_VERIFY_BLOCK, CMD_VERIFY_SECTION, CMD_READ_ONCE,
      CMD_PROGRAM, CMD_PROGRAM_ONCE, CMD_ERASE_ALL, CMD_ERASE_BLOCK,
      CMD_ERASE_SECTOR, CMD_UNSECURE, CMD_BACKDOOR, CMD_USER_MARGIN,
      CMD_FIELD_MARGIN, CMD_EE_VERIFY, CMD_EE_PROGRAM, CMD_EE_ERASE,
      CMD_PROT_OVERRIDE: listed = 1'b1;
      default: listed = 1'b0;
    endcase
    ss_only = (code == CMD_ERASE_ALL) || (code == CMD_UNSECURE) || (code == CMD_FIELD_MARGIN);
    ns_only = (code == CMD_BACKDOOR);
    prog_erase = (code == CMD_PROGRAM) || (code == CMD_PROGRAM_ONCE) || (code == CMD_ERASE_ALL) ||
                 (code == CMD_ERASE_BLOCK) || (code == CMD_ERASE_SECTOR) || (code == CMD_UNSECURE) ||
                 (code == CMD_EE_PROGRAM) || (code == CMD_EE_ERASE);
    // secured normal mode shares the unsecured normal set
    code_ok = listed && !(secured && special_mode) && (special_mode ? !ns_only : !ss_only);
    acc_fail = !code_ok || (prog_erase && !div_loaded);
    prot_fail = 1'b0;
    if (code == CMD_ERASE_ALL) begin
      prot_fail = (prot != PROT_ALL);
    end else if (code == CMD_ERASE_BLOCK && pf_target) begin
      prot_fail = (prot[PROT_PF_OPEN_BIT:PROT_LOW_DIS_BIT] != PROT_PF_ALL);
    end
  end
endmodule // nvm_cmd_check
`default_nettype wire

// ---- nvm_command_launch_control.sv ----
// nvm command launch control: ahb-lite registers, launch handshake, controller port
`timescale 1ns/1ps
`default_nettype none
module nvm_command_launch_control (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // chip mode and security
  input wire logic special_mode,
  input wire logic secured,
  // memory controller side
  output logic mc_start,
  output logic [7:0] mc_code,
  output logic [23:0] mc_addr,
  output logic [15:0] mc_data0,
  output logic [15:0] mc_data1,
  output logic [15:0] mc_data2,
  output logic [15:0] mc_data3,
  output logic [2:0] mc_word_count,
  input wire logic mc_done,
  input wire logic mc_viol,
  input wire logic mc_wr_en,
  input wire logic [2:0] mc_wr_index,
  input wire logic [15:0] mc_wr_data
);
  import nvm_launch_pkg::*;

  typedef struct packed {
    launch_state_e st;
    logic command_complete_flag;
    logic acc;
    logic viol;
    logic [IDX_W-1:0] idx;
    logic div_ld;
    logic [DIV_W-1:0] div;
    logic [3:0] prot;
    logic [OBJ_WORDS-1:0][15:0] obj;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic start;
  } state_s;

  state_s q, d;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  logic addr_take;
  logic [7:0] a_addr;
  logic obj_hit;
  logic [IDX_W-1:0] obj_sel;
  logic [7:0] obj_off;
  logic [31:0] rd_val;

  assign addr_take = hsel && htrans[1] && hready;
  assign a_addr = haddr[7:0];

  function automatic logic in_obj(input logic [7:0] a);
    in_obj = (a >= ADDR_OBJ_BASE) && (a < ADDR_OBJ_END) && (a[1:0] == 2'h0);
  endfunction

  // the data-phase write decodes the latched address
  assign obj_hit = in_obj(q.wr_addr);
  assign obj_off = q.wr_addr - ADDR_OBJ_BASE;
  assign obj_sel = obj_off[OBJ_SEL_LSB +: IDX_W];

  // read value for the address phase; upper bits of narrow registers read zero
  always_comb begin
    logic [7:0] roff;
    roff = a_addr - ADDR_OBJ_BASE;
    rd_val = 32'h0;
    if (haddr[31:8] == 24'h0) begin
      if (a_addr == ADDR_STATUS) begin
        rd_val[COMMAND_COMPLETE_FLAG_BIT] = q.command_complete_flag;
        rd_val[ACC_BIT] = q.acc;
        rd_val[VIOL_BIT] = q.viol;
      end else if (a_addr == ADDR_INDEX) begin
        rd_val[IDX_W-1:0] = q.idx;
      end else if (a_addr == ADDR_CLKDIV) begin
        rd_val[DIV_W-1:0] = q.div;
        rd_val[DIV_LOADED_BIT] = q.div_ld;
      end else if (a_addr == ADDR_PROT) begin
        rd_val[3:0] = q.prot;
      end else if (in_obj(a_addr)) begin
        rd_val[15:0] = q.obj[roff[OBJ_SEL_LSB +: IDX_W]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // launch decision

  logic wr_status, launch_try, err_free, launch_go;
  logic acc_fail, prot_fail;
  logic wr_obj;
  logic pf_target;

  assign wr_status = q.wr_pend && (q.wr_addr == ADDR_STATUS);
  assign wr_obj = q.wr_pend && obj_hit;
  // a launch is only meaningful while no command runs
  assign launch_try = wr_status && hwdata[COMMAND_COMPLETE_FLAG_BIT] && q.command_complete_flag;
  assign err_free = !q.acc && !q.viol;
  assign launch_go = launch_try && err_free && !acc_fail && !prot_fail;
  assign pf_target = q.obj[0][PF_ADDR_BIT];

  nvm_cmd_check u_check (
    .code(q.obj[0][15:8]),
    .pf_target(pf_target),
    .special_mode(special_mode),
    .secured(secured),
    .div_loaded(q.div_ld),
    .prot(q.prot),
    .acc_fail(acc_fail),
    .prot_fail(prot_fail)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    d = q;
    d.start = 1'b0;
    d.wr_pend = addr_take && hwrite;
    if (addr_take) begin
      d.wr_addr = haddr[31:8] == 24'h0 ? a_addr : 8'hff;
    end
    if (addr_take && !hwrite) begin
      d.rdata = rd_val;
    end
    // error flags: software clear first, hardware set after so the set wins
    if (wr_status && hwdata[ACC_BIT]) begin
      d.acc = 1'b0;
    end
    if (wr_status && hwdata[VIOL_BIT]) begin
      d.viol = 1'b0;
    end
    unique case (q.st)
      st_idle: begin
        if (q.wr_pend && q.wr_addr == ADDR_INDEX) begin
          d.idx = hwdata[IDX_W-1:0];
        end
        if (q.wr_pend && q.wr_addr == ADDR_CLKDIV) begin
          d.div = hwdata[DIV_W-1:0];
          d.div_ld = 1'b1;
        end
        if (q.wr_pend && q.wr_addr == ADDR_PROT) begin
          d.prot = hwdata[3:0];
        end
        if (wr_obj && obj_sel < IDX_W'(OBJ_WORDS)) begin
          d.obj[obj_sel] = hwdata[15:0];
        end
        if (launch_try && err_free) begin
          if (acc_fail) begin
            d.acc = 1'b1;
          end else if (prot_fail) begin
            d.viol = 1'b1;
          end else begin
            d.command_complete_flag = 1'b0;
            d.start = 1'b1;
            d.st = st_busy;
          end
        end
      end
      st_busy: begin
        // software writes to the array, index and protection are dropped here
        if (mc_wr_en && mc_wr_index < IDX_W'(OBJ_WORDS)) begin
          d.obj[mc_wr_index] = mc_wr_data;
        end
        if (mc_done) begin
          d.command_complete_flag = 1'b1;
          d.st = st_idle;
          if (mc_viol) begin
            d.viol = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
      q.command_complete_flag <= 1'b1;
      q.prot <= PROT_RESET;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  // zero wait states keep the slave simple; reads are sampled in the address phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign mc_start = q.start;
  assign mc_code = q.obj[0][15:8];
  assign mc_addr = {q.obj[0][7:0], q.obj[1]};
  assign mc_data0 = q.obj[2];
  assign mc_data1 = q.obj[3];
  assign mc_data2 = q.obj[4];
  assign mc_data3 = q.obj[5];
  assign mc_word_count = q.idx;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_launch_starts: assert property (launch_go |=> (!q.command_complete_flag && q.start && q.st == st_busy))
    else $error("valid launch did not start the command");

  chk_start_pulse: assert property (q.start |=> !q.start)
    else $error("start longer than one cycle");

  chk_busy_locks_obj: assert property ((q.st == st_busy && wr_obj && !mc_wr_en) |=> $stable(q.obj))
    else $error("command array changed by software while busy");

  chk_busy_locks_index: assert property ((q.st == st_busy) |=> $stable(q.idx) && $stable(q.prot))
    else $error("parameters changed while busy");

  chk_command_complete_flag_held_low: assert property ((q.st == st_busy && !mc_done) |=> !q.command_complete_flag)
    else $error("complete flag rose before the command finished");

  chk_done_returns: assert property ((q.st == st_busy && mc_done) |=> (q.command_complete_flag && q.st == st_idle))
    else $error("complete flag not returned on done");

  chk_invalid_code: assert property ((launch_try && err_free && acc_fail) |=> (q.acc && q.command_complete_flag && !q.start))
    else $error("invalid launch not flagged or processed anyway");

  chk_no_divider: assert property ((launch_try && err_free && !q.div_ld && mc_code == CMD_PROGRAM)
    |=> (q.acc && !q.start))
    else $error("program ran without divider");

  chk_secure_special: assert property ((launch_try && secured && special_mode) |=> !q.start)
    else $error("command started in secured special mode");

  chk_mode_table: assert property ((launch_go && ((mc_code == CMD_ERASE_ALL) || (mc_code == CMD_UNSECURE)
    || (mc_code == CMD_FIELD_MARGIN))) |-> (special_mode && !secured))
    else $error("special-only code started outside unsecured special mode");

  chk_backdoor_mode: assert property ((launch_go && mc_code == CMD_BACKDOOR) |-> !special_mode)
    else $error("backdoor verify started in special mode");

  chk_secured_normal: assert property ((launch_try && err_free && secured && !special_mode && q.div_ld
    && mc_code == CMD_PROGRAM) |=> q.start)
    else $error("normal command refused in secured normal mode");

  chk_erase_all_prot: assert property ((launch_try && err_free && !acc_fail && mc_code == CMD_ERASE_ALL
    && q.prot != PROT_ALL) |=> (q.viol && !q.start))
    else $error("erase all started without all protection bits open");

  chk_block_prot: assert property ((launch_go && mc_code == CMD_ERASE_BLOCK && pf_target)
    |-> (q.prot[PROT_PF_OPEN_BIT:PROT_LOW_DIS_BIT] == PROT_PF_ALL))
    else $error("flash block erase started while protected");

  chk_error_blocks: assert property ((launch_try && !err_free) |=> (q.command_complete_flag && !q.start))
    else $error("launch accepted with error flag set");

  chk_acc_set_wins: assert property ((launch_try && err_free && acc_fail) |=> q.acc)
    else $error("access error set lost");

  // a software clear in the done cycle must not hide a violation from the controller
  chk_viol_set_wins: assert property ((q.st == st_busy && mc_done && mc_viol) |=> q.viol)
    else $error("controller violation lost against a clear");

endmodule // nvm_command_launch_control
`default_nettype wire

// ---- nvm_command_launch_control_test.sv ----
// self-checking bench for the nvm command launch control block
`timescale 1ns/1ps
`default_nettype none
module nvm_command_launch_control_test;
  import nvm_launch_pkg::*;
  typedef struct packed {logic [31:0] e; logic [31:0] m;} note_s;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, mc_start;
  logic [31:0] hrdata;
  logic special_mode = 1'b0;
  logic secured = 1'b0;
  logic [7:0] mc_code;
  logic [23:0] mc_addr;
  logic [15:0] mc_data0;
  logic [15:0] mc_data1;
  logic [15:0] mc_data2;
  logic [15:0] mc_data3;
  logic [2:0] mc_word_count;
  logic mc_done = 1'b0;
  logic mc_viol = 1'b0;
  logic mc_wr_en = 1'b0;
  logic [2:0] mc_wr_index = 3'h0;
  logic [15:0] mc_wr_data = 16'h0;
  int num_errors = 0;
  int check_count = 0;
  note_s rd_q[$];
  logic [63:0] go_q[$];
  logic [47:0] dat_q[$];
  logic rd_pend = 1'b0;

  always #25 hclk = ~hclk;

  nvm_command_launch_control uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .special_mode(special_mode), .secured(secured), .mc_start(mc_start),
    .mc_code(mc_code), .mc_addr(mc_addr), .mc_data0(mc_data0), .mc_data1(mc_data1), .mc_data2(mc_data2),
    .mc_data3(mc_data3),
    .mc_word_count(mc_word_count), .mc_done(mc_done), .mc_viol(mc_viol), .mc_wr_en(mc_wr_en),
    .mc_wr_index(mc_wr_index), .mc_wr_data(mc_wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic compare(input string what, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict;
    if (num_errors == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // monitor: reads end at the data-phase edge, starts are one-cycle pulses
  always @(posedge hclk) begin : watch
    note_s n;
    if (rd_pend) begin
      n = rd_q.pop_front();
      compare("read data", {32'h0, hrdata & n.m}, {32'h0, n.e & n.m});
      compare("hresp", {63'h0, hresp}, 64'h0);
    end
    if (mc_start === 1'b1) begin
      if (go_q.size() == 0) begin
        compare("unexpected start", 64'h1, 64'h0);
      end else begin
        compare("start params", {13'h0, mc_code, mc_addr, mc_word_count, mc_data0}, go_q.pop_front());
        compare("start data", {16'h0, mc_data1, mc_data2, mc_data3}, {16'h0, dat_q.pop_front()});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    rd_pend <= !w;
    wait_rdy();
    rd_pend <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'h0000ffff);
    rd_q.push_back('{e, m});
    bus(a, 1'b0, 32'h0);
  endtask

  // only the three defined status bits are compared
  task automatic rds(input logic [7:0] e);
    rd(ADDR_STATUS, {24'h0, e}, 32'h000000b0);
  endtask

  function automatic bit legal(input logic [7:0] c, input bit sp, input bit sec);
    if (sp && sec) return 1'b0;
    case (c)
      8'h08, 8'h0b, 8'h0e: return sp;
      8'h0c: return !sp;
      8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0a, 8'h0d, 8'h10, 8'h11, 8'h12, 8'h13: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // one launch attempt; pv: refused with a protection violation, v: controller reports one
  task automatic try(input logic [7:0] c, input logic [7:0] lo, input bit ok, input bit pv, input bit v);
    logic [15:0] w1, rv;
    logic [2:0] ix;
    logic [47:0] w3;
    w1 = 16'($urandom());
    w3 = {$urandom(), 16'($urandom())};
    rv = 16'($urandom());
    ix = 3'($urandom_range(5, 1));
    wr(ADDR_OBJ_BASE, {16'h0, c, lo});
    wr(8'h14, {16'h0, w1});
    wr(8'h18, {16'h0, ~w1});
    wr(8'h1c, {16'h0, w3[47:32]});
    wr(8'h20, {16'h0, w3[31:16]});
    wr(8'h24, {16'h0, w3[15:0]});
    wr(ADDR_INDEX, {29'h0, ix});
    if (ok) go_q.push_back({13'h0, c, lo, w1, ix, ~w1});
    if (ok) dat_q.push_back(w3);
    wr(ADDR_STATUS, 32'h80);
    if (ok) begin
      rds(8'h00);
      wr(8'h14, {16'h0, ~w1});
      wr(ADDR_STATUS, 32'h80);
      mc_wr_en <= 1'b1;
      mc_wr_index <= 3'h2;
      mc_wr_data <= rv;
      @(posedge hclk);
      mc_wr_en <= 1'b0;
      mc_done <= 1'b1;
      mc_viol <= v;
      @(posedge hclk);
      mc_done <= 1'b0;
      mc_viol <= 1'b0;
      rds(v ? 8'h90 : 8'h80);
      rd(8'h14, {16'h0, w1});
      rd(8'h18, {16'h0, rv});
    end else begin
      rds(pv ? 8'h90 : 8'ha0);
      wr(ADDR_STATUS, 32'h30);
      rds(8'h80);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'heae6));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rds(8'h80);
    rd(ADDR_INDEX, 32'h0);
    rd(ADDR_CLKDIV, 32'h0);
    rd(ADDR_PROT, 32'h0);
    rd(ADDR_OBJ_BASE, 32'h0);
    wr(8'h40, 32'hffffffff);
    rd(8'h40, 32'h0, 32'hffffffff);
    // divider not yet written: program refused, verify still runs
    try(CMD_PROGRAM, 8'h00, 1'b0, 1'b0, 1'b0);
    try(CMD_VERIFY_ALL, 8'h00, 1'b1, 1'b0, 1'b0);
    wr(ADDR_CLKDIV, 32'h05);
    rd(ADDR_CLKDIV, 32'h85);
    wr(ADDR_PROT, 32'h0f);
    rd(ADDR_PROT, 32'h0f);
    for (int m = 0; m < 4; m++) begin
      special_mode <= m[1];
      secured <= m[0];
      for (int c = 0; c < 21; c++) begin
        try(8'(c), 8'h00, legal(8'(c), m[1], m[0]), 1'b0, 1'b0);
      end
    end
    special_mode <= 1'b1;
    secured <= 1'b0;
    wr(ADDR_PROT, 32'h03);
    try(CMD_ERASE_ALL, 8'h00, 1'b0, 1'b1, 1'b0);
    try(CMD_ERASE_BLOCK, 8'h80, 1'b0, 1'b1, 1'b0);
    try(CMD_ERASE_BLOCK, 8'h00, 1'b1, 1'b0, 1'b0);
    wr(ADDR_PROT, 32'h07);
    try(CMD_ERASE_ALL, 8'h00, 1'b0, 1'b1, 1'b0);
    try(CMD_ERASE_BLOCK, 8'h80, 1'b1, 1'b0, 1'b1);
    // violation left set by the controller blocks the next launch
    try(CMD_VERIFY_ALL, 8'h00, 1'b0, 1'b1, 1'b0);
    repeat (3) @(posedge hclk);
    compare("pending notes", 64'(rd_q.size() + go_q.size() + dat_q.size()), 64'h0);
    give_verdict();
  end
endmodule // nvm_command_launch_control_test
`default_nettype wire
